/* cprc_clk_div.sv */
`timescale 1ns/1ps
`include "cprc_defs.svh"

// Enable-pulse divider; a new ratio is adopted only at a period boundary.
module cprc_clk_div
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  output logic            en_o
);

  logic [`CPRC_DIV_CNT_W-1:0] cnt_r;
  logic [2:0]                 sel_r;

  function automatic logic [`CPRC_DIV_CNT_W-1:0] last_of(input logic [2:0] s);
    last_of = `CPRC_DIV_CNT_W'((8'h01 << s) - 8'h01);
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      sel_r <= 3'h0;
      en_o  <= 1'b0;
    end
    else if (!run_i)
    begin
      en_o <= 1'b0;
    end
    else if (cnt_r >= last_of(sel_r))
    begin
      // Ratio changes only here, so no short period is ever produced.
      cnt_r <= '0;
      sel_r <= sel_i;
      en_o  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      en_o  <= 1'b0;
    end
  end

endmodule // cprc_clk_div

/* cprc_ctrl.sv */
// Function
// - Power-save enable divides internal clock
// - Divisor codes select divide 1 to 128
// - External interrupt clears power-save enable
// - Frequency bit picks crystal or internal
// - Drive-disable bit three-states clock pin
// - Latch delay bit adds one T1
// - Midrange select zero covers whole range
// - Gate bits stop five peripheral clocks
// - Power-down bit stops crystal clock
// - Wake enables let interrupt lines wake
// - Count 19-bit stabilisation before release
// - Wake flag set on interrupt wake-up
// - After wake, restore or full speed
// - PLL output equals ref times N/(M*R)
// - Pre-divider M equals code plus one
// - Post-divider R is 1,2,4,8
// - Feedback N equals code plus one
// - PLL factor one after reset
// - Latch bus pins at reset release
// - Halving strap low divides input by two
// - Either memory-select strap low floats all pins
`timescale 1ns/1ps
`include "cprc_defs.svh"

module cprc_ctrl
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire cprc_pkg::cprc_req_s   req_i,
  output logic [15:0]                rdata_o,
  input  wire logic [15:0]           strap_bus_i,
  input  wire logic                  halve_input_clock_strap_i,
  input  wire logic                  upper_memory_select_strap_i,
  input  wire logic                  low_memory_select_strap_i,
  input  wire logic [4:0]            ext_irq_i,
  input  wire logic                  irq_enable_i,
  input  wire logic                  irq_serviced_i,
  output logic                       core_clk_en_o,
  output cprc_pkg::cprc_pin_s        clock_output_a_o,
  output cprc_pkg::cprc_pin_s        clock_output_b_o,
  output logic [4:0]                 periph_clk_stop_o,
  output logic                       address_latch_delay_o,
  output logic                       midrange_sel0_whole_range_o,
  output logic                       crystal_stop_o,
  output logic                       pin_float_test_mode_o,
  output logic [1:0]                 pll_pre_divider_o,
  output logic [1:0]                 pll_post_divider_o,
  output logic [4:0]                 pll_feedback_divider_o
);

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  logic [4:0]  irq_s1_r;
  logic [4:0]  irq_s2_r;
  logic [2:0]  strap_s1_r;
  logic [2:0]  strap_s2_r;
  logic [15:0] bus_s1_r;
  logic [15:0] bus_s2_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_s1_r   <= 5'h00;
      irq_s2_r   <= 5'h00;
      strap_s1_r <= 3'h7;
      strap_s2_r <= 3'h7;
      bus_s1_r   <= `CPRC_RST_ZERO;
      bus_s2_r   <= `CPRC_RST_ZERO;
    end
    else
    begin
      irq_s1_r   <= ext_irq_i;
      irq_s2_r   <= irq_s1_r;
      strap_s1_r <= {halve_input_clock_strap_i, upper_memory_select_strap_i,
                     low_memory_select_strap_i};
      strap_s2_r <= strap_s1_r;
      bus_s1_r   <= strap_bus_i;
      bus_s2_r   <= bus_s1_r;
    end
  end

  // ---------------------------------------------------------------------
  // Strap capture at reset release
  // ---------------------------------------------------------------------
  // The straps are taken on the third edge after release, pin_float_test_mode the
  // synchronisers hold real pin values; they then stay until next reset.
  logic [1:0]  cap_cnt_r;
  logic        captured_r;
  logic [15:0] reset_strap_bits_r;
  logic        halve_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap_cnt_r             <= 2'h0;
      captured_r            <= 1'b0;
      reset_strap_bits_r    <= `CPRC_RST_ZERO;
      halve_r               <= 1'b0;
      pin_float_test_mode_o <= 1'b0;
    end
    else if (!captured_r)
    begin
      cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == `CPRC_CAP_LAST)
      begin
        captured_r            <= 1'b1;
        reset_strap_bits_r    <= bus_s2_r;
        halve_r               <= ~strap_s2_r[2];
        pin_float_test_mode_o <= ~strap_s2_r[1] | ~strap_s2_r[0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [15:0] psctl_r;
  logic [15:0] pdcfg_r;
  logic [15:0] gate_r;
  logic [15:0] pll_r;
  logic        wif_r;
  logic        wr_ps;
  logic        wr_pd;
  logic        ext_irq_evt;
  logic        wake_done;
  logic [2:0]  saved_div_r;
  logic        saved_ps_r;

  assign wr_ps       = req_i.wr && (req_i.addr == `CPRC_OFF_PSCTL);
  assign wr_pd       = req_i.wr && (req_i.addr == `CPRC_OFF_PDCFG);
  assign ext_irq_evt = |irq_s2_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      psctl_r <= `CPRC_RST_ZERO;
    end
    else if (ext_irq_evt)
    begin
      // Hardware clear wins over a simultaneous software set.
      psctl_r[`CPRC_PS_EN] <= 1'b0;
      if (wr_ps)
      begin
        psctl_r[`CPRC_PS_EN-1:0] <= `CPRC_PS_EN'(req_i.wdata & `CPRC_PS_MASK);
      end
    end
    else if (wake_done && !irq_enable_i)
    begin
      psctl_r[`CPRC_PS_EN] <= saved_ps_r;
      psctl_r[`CPRC_PS_DIV_HI:0] <= saved_div_r;
    end
    else if (wr_ps)
    begin
      psctl_r <= req_i.wdata & `CPRC_PS_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_r <= `CPRC_RST_ZERO;
      pll_r  <= `CPRC_RST_ZERO;
    end
    else if (req_i.wr)
    begin
      if (req_i.addr == `CPRC_OFF_PCLKGT)
      begin
        gate_r <= req_i.wdata & `CPRC_GT_MASK;
      end
      else if (req_i.addr == `CPRC_OFF_PLL)
      begin
        pll_r <= req_i.wdata & `CPRC_PLL_MASK;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Power-down state machine
  // ---------------------------------------------------------------------
  cprc_pkg::cprc_pwr_e     state_r;
  logic [`CPRC_STAB_BITS-1:0] stab_r;
  logic                    wake_hit;

  assign wake_hit  = |(irq_s2_r & pdcfg_r[`CPRC_PD_WAKE_HI:0]);
  assign wake_done = (state_r == cprc_pkg::CPRC_STAB) && (stab_r == `CPRC_STAB_MAX);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r     <= cprc_pkg::CPRC_RUN;
      stab_r      <= '0;
      pdcfg_r     <= `CPRC_RST_ZERO;
      wif_r       <= 1'b0;
      saved_div_r <= 3'h0;
      saved_ps_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        cprc_pkg::CPRC_RUN:
        begin
          if (wr_pd)
          begin
            pdcfg_r <= req_i.wdata & `CPRC_PD_MASK;
            wif_r   <= 1'b0;
            if (req_i.wdata[`CPRC_PD_PWD])
            begin
              saved_div_r <= psctl_r[`CPRC_PS_DIV_HI:0];
              saved_ps_r  <= psctl_r[`CPRC_PS_EN];
              state_r     <= cprc_pkg::CPRC_DOWN;
            end
          end
          if (irq_serviced_i)
          begin
            wif_r <= 1'b0;
          end
        end
        cprc_pkg::CPRC_DOWN:
        begin
          if (wake_hit)
          begin
            stab_r  <= '0;
            wif_r   <= 1'b1;
            state_r <= cprc_pkg::CPRC_STAB;
          end
        end
        cprc_pkg::CPRC_STAB:
        begin
          stab_r <= stab_r + 1'b1;
          if (wake_done)
          begin
            pdcfg_r[`CPRC_PD_PWD] <= 1'b0;
            state_r               <= cprc_pkg::CPRC_RUN;
          end
        end
        default:
        begin
          state_r <= cprc_pkg::CPRC_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Clock enables and outputs
  // ---------------------------------------------------------------------
  logic       run;
  logic       div_en;
  logic       halve_ph_r;
  logic [2:0] div_sel;

  assign run     = (state_r == cprc_pkg::CPRC_RUN);
  assign div_sel = psctl_r[`CPRC_PS_EN] ? psctl_r[`CPRC_PS_DIV_HI:0] : 3'h0;

  cprc_clk_div cprc_clk_div_inst
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run && (!halve_r || halve_ph_r)),
    .sel_i   (div_sel),
    .en_o    (div_en)
  );

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halve_ph_r                  <= 1'b0;
      core_clk_en_o               <= 1'b0;
      clock_output_a_o            <= '0;
      clock_output_b_o            <= '0;
      periph_clk_stop_o           <= 5'h00;
      address_latch_delay_o       <= 1'b0;
      midrange_sel0_whole_range_o <= 1'b0;
      crystal_stop_o              <= 1'b0;
      pll_pre_divider_o           <= 2'h0;
      pll_post_divider_o          <= 2'h0;
      pll_feedback_divider_o      <= 5'h00;
    end
    else
    begin
      halve_ph_r     <= ~halve_ph_r;
      // Enable pulses, never partial clocks, keep edges whole.
      core_clk_en_o  <= div_en;
      crystal_stop_o <= (state_r == cprc_pkg::CPRC_DOWN);
      clock_output_a_o.o  <= psctl_r[`CPRC_PS_CAF] ? run : div_en;
      clock_output_a_o.oe <= ~psctl_r[`CPRC_PS_CAD] & ~pin_float_test_mode_o;
      clock_output_b_o.o  <= psctl_r[`CPRC_PS_CBF] ? run : div_en;
      clock_output_b_o.oe <= ~psctl_r[`CPRC_PS_CBD] & ~pin_float_test_mode_o;
      periph_clk_stop_o           <= gate_r[`CPRC_GT_HI:`CPRC_GT_LO];
      address_latch_delay_o       <= psctl_r[`CPRC_PS_ALE];
      midrange_sel0_whole_range_o <= psctl_r[`CPRC_PS_MCS];
      // PLL settings are handed to the analog block only while clocks run.
      if (div_en)
      begin
        pll_pre_divider_o      <= pll_r[`CPRC_PLL_PRS_HI:`CPRC_PLL_PRS_LO];
        pll_post_divider_o     <= pll_r[`CPRC_PLL_POS_HI:`CPRC_PLL_POS_LO];
        pll_feedback_divider_o <= pll_r[`CPRC_PLL_FBS_HI:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= `CPRC_RST_ZERO;
    end
    else if (!req_i.rd)
    begin
      rdata_o <= `CPRC_RST_ZERO;
    end
    else if (req_i.addr == `CPRC_OFF_PSCTL)
    begin
      rdata_o <= psctl_r;
    end
    else if (req_i.addr == `CPRC_OFF_PDCFG)
    begin
      rdata_o <= pdcfg_r | {7'h00, wif_r, 8'h00};
    end
    else if (req_i.addr == `CPRC_OFF_PCLKGT)
    begin
      rdata_o <= gate_r;
    end
    else if (req_i.addr == `CPRC_OFF_STRAP)
    begin
      rdata_o <= reset_strap_bits_r;
    end
    else if (req_i.addr == `CPRC_OFF_PLL)
    begin
      rdata_o <= pll_r;
    end
    else
    begin
      rdata_o <= `CPRC_RST_ZERO;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_irq_clears_ps: assert property (ext_irq_evt |=> !psctl_r[`CPRC_PS_EN])
    else $error("power save enable survived an interrupt");
  a_pd_entry: assert property (run && wr_pd && req_i.wdata[`CPRC_PD_PWD]
    |=> state_r == cprc_pkg::CPRC_DOWN)
    else $error("power down not entered");
  a_crystal_stop: assert property ($rose(state_r == cprc_pkg::CPRC_DOWN)
    |=> crystal_stop_o)
    else $error("crystal not stopped");
  a_wake_sets_flag: assert property (state_r == cprc_pkg::CPRC_DOWN && wake_hit
    |=> wif_r && state_r == cprc_pkg::CPRC_STAB)
    else $error("wake flag not set");
  a_no_wake_masked: assert property (state_r == cprc_pkg::CPRC_DOWN && !wake_hit
    |=> state_r == cprc_pkg::CPRC_DOWN)
    else $error("woke without enabled line");
  a_stab_no_clk: assert property (state_r == cprc_pkg::CPRC_STAB
    |=> ##1 !core_clk_en_o)
    else $error("core clock during stabilisation");
  a_clka_float: assert property (psctl_r[`CPRC_PS_CAD] |=> !clock_output_a_o.oe)
    else $error("clock output a driven while disabled");
  a_gate_bits: assert property (##1 periph_clk_stop_o
    == $past(gate_r[`CPRC_GT_HI:`CPRC_GT_LO]))
    else $error("peripheral gate mismatch");
  a_ale_bit: assert property (##1 address_latch_delay_o
    == $past(psctl_r[`CPRC_PS_ALE]))
    else $error("latch delay mismatch");
  // The divider adopts a new ratio only at a period boundary, so full speed is
  // judged by the ratio it actually runs, not by the register field.
  a_full_speed: assert property (run && !halve_r && cprc_clk_div_inst.sel_r == 3'h0
    |-> ##2 core_clk_en_o)
    else $error("full speed not continuous");

  c_power_down: cover property (state_r == cprc_pkg::CPRC_DOWN);
  c_wake: cover property (wake_done);
  c_div128: cover property (psctl_r[`CPRC_PS_EN] && div_sel == 3'h7 && div_en);
  c_float: cover property (pin_float_test_mode_o);

endmodule // cprc_ctrl

/* cprc_defs.svh */
`ifndef CPRC_DEFS_SVH
`define CPRC_DEFS_SVH

// Register offsets in the peripheral control block.
`define CPRC_OFF_PDCFG    8'h46
`define CPRC_OFF_PSCTL    8'hF0
`define CPRC_OFF_PCLKGT   8'hFA
`define CPRC_OFF_STRAP    8'hF6
`define CPRC_OFF_PLL      8'hF8

// Power-save control fields.
`define CPRC_PS_EN        15
`define CPRC_PS_MCS       14
`define CPRC_PS_CBF       11
`define CPRC_PS_CBD       10
`define CPRC_PS_CAF       9
`define CPRC_PS_CAD       8
`define CPRC_PS_ALE       4
`define CPRC_PS_DIV_HI    2
`define CPRC_PS_MASK      16'hCF17

// Power-down configuration fields.
`define CPRC_PD_PWD       15
`define CPRC_PD_WIF       8
`define CPRC_PD_WAKE_HI   4
`define CPRC_PD_MASK      16'h801F

// Peripheral clock gate and PLL fields.
`define CPRC_GT_MASK      16'hF800
`define CPRC_GT_HI        15
`define CPRC_GT_LO        11
`define CPRC_PLL_MASK     16'h0F1F
`define CPRC_PLL_PRS_HI   11
`define CPRC_PLL_PRS_LO   10
`define CPRC_PLL_POS_HI   9
`define CPRC_PLL_POS_LO   8
`define CPRC_PLL_FBS_HI   4

// Reset values.
`define CPRC_RST_ZERO     16'h0000

// Stabilisation counter width after wake-up.
`define CPRC_STAB_BITS    19
`define CPRC_STAB_MAX     19'h7FFFF

// Divider counter width and the edge after release at which straps are taken.
`define CPRC_DIV_CNT_W    7
`define CPRC_CAP_LAST     2'h2

`endif

/* cprc_pkg.sv */
package cprc_pkg;

  typedef enum logic [1:0]
  {
    CPRC_RUN  = 2'b00,
    CPRC_DOWN = 2'b01,
    CPRC_STAB = 2'b11
  } cprc_pwr_e;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cprc_req_s;

  typedef struct packed
  {
    logic o;
    logic oe;
  } cprc_pin_s;

endpackage

/* tb_top.sv */
`timescale 1ns/1ps
`include "cprc_defs.svh"

module tb_top;
  logic                clk_i;
  logic                rst_n_i;
  cprc_pkg::cprc_req_s req;
  logic [15:0]         rdata;
  logic [15:0]         strap_bus;
  logic                halve_n;
  logic                ums_n;
  logic                lms_n;
  logic [4:0]          ext_irq;
  logic                irq_en;
  logic                irq_svc;
  logic                core_en;
  cprc_pkg::cprc_pin_s clk_a;
  cprc_pkg::cprc_pin_s clk_b;
  logic [4:0]          pstop;
  logic                ale_dly;
  logic                mcs_all;
  logic                xtal_stop;
  logic                pin_float;
  logic [1:0]          pre;
  logic [1:0]          post;
  logic [4:0]          fb;
  logic [31:0]         exp_q[$];
  logic [31:0]         note;
  logic [15:0]         d;
  integer              seed = 32'h9087;
  int                  mismatches = 0;
  int                  check_count = 0;
  int                  n;

  cprc_ctrl cprc_ctrl_inst
  (
    .clk_i                       (clk_i),
    .rst_n_i                     (rst_n_i),
    .req_i                       (req),
    .rdata_o                     (rdata),
    .strap_bus_i                 (strap_bus),
    .halve_input_clock_strap_i   (halve_n),
    .upper_memory_select_strap_i (ums_n),
    .low_memory_select_strap_i   (lms_n),
    .ext_irq_i                   (ext_irq),
    .irq_enable_i                (irq_en),
    .irq_serviced_i              (irq_svc),
    .core_clk_en_o               (core_en),
    .clock_output_a_o            (clk_a),
    .clock_output_b_o            (clk_b),
    .periph_clk_stop_o           (pstop),
    .address_latch_delay_o       (ale_dly),
    .midrange_sel0_whole_range_o (mcs_all),
    .crystal_stop_o              (xtal_stop),
    .pin_float_test_mode_o       (pin_float),
    .pll_pre_divider_o           (pre),
    .pll_post_divider_o          (post),
    .pll_feedback_divider_o      (fb)
  );

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    int r;
    r = $random(seed);
    return r[15:0];
  endfunction

  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  // The expected word is noted with its mask; the monitor below compares it.
  task rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] m);
    @(posedge clk_i);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    exp_q.push_back({m, v});
    @(posedge clk_i);
    req.rd <= 1'b0;
  endtask

  task settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // Cycles from one enable pulse to the next, bounded so a stuck divider cannot hang.
  task gap(output int p);
    int k;
    k = 0;
    do begin @(posedge clk_i); #1; k++; end while (core_en !== 1'b1 && k < 400);
    p = 0;
    do begin @(posedge clk_i); #1; p++; end while (core_en !== 1'b1 && p < 400);
  endtask

  task pulse_irq(input int k);
    @(posedge clk_i);
    ext_irq[k] <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_irq <= 5'h00;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task do_reset(input logic h, input logic u, input logic l);
    rst_n_i   <= 1'b0;
    halve_n   <= h;
    ums_n     <= u;
    lms_n     <= l;
    strap_bus <= rnd();
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  always @(posedge clk_i)
  begin
    if (req.rd === 1'b1)
    begin
      #1;
      note = exp_q.pop_front();
      chk(rdata & note[31:16], note[15:0], "read data");
    end
  end

  initial
  begin
    #500000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    req     <= '0;
    ext_irq <= 5'h00;
    irq_en  <= 1'b0;
    irq_svc <= 1'b0;
    do_reset(1'b1, 1'b1, 1'b1);
    rd(`CPRC_OFF_PDCFG, 16'h0000, 16'hFFFF);
    rd(`CPRC_OFF_PSCTL, 16'h0000, 16'hFFFF);
    rd(`CPRC_OFF_PCLKGT, 16'h0000, 16'hFFFF);
    rd(`CPRC_OFF_PLL, 16'h0000, 16'hFFFF);
    rd(`CPRC_OFF_STRAP, strap_bus, 16'hFFFF);
    rd(8'h10, 16'h0000, 16'hFFFF);
    chk({pre, post, fb}, 16'h0000, "pll codes after reset");
    chk(pin_float, 1'b0, "float mode without straps");
    wr(`CPRC_OFF_STRAP, ~strap_bus);
    rd(`CPRC_OFF_STRAP, strap_bus, 16'hFFFF);
    done("reset values");

    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      wr(`CPRC_OFF_PSCTL, d & 16'h7FFF);
      wr(`CPRC_OFF_PLL, d);
      wr(`CPRC_OFF_PCLKGT, d);
      settle();
      chk(ale_dly, d[4], "latch delay");
      chk(mcs_all, d[14], "midrange whole range");
      chk(pstop, d[15:11], "peripheral stops");
      chk({pre, post, fb}, {d[11:8], d[4:0]}, "pll codes");
      chk(clk_a.oe, !d[8], "pin a enable");
      chk(clk_b.oe, !d[10], "pin b enable");
      rd(`CPRC_OFF_PSCTL, d & `CPRC_PS_MASK & 16'h7FFF, 16'hFFFF);
      rd(`CPRC_OFF_PLL, d & `CPRC_PLL_MASK, 16'hFFFF);
      rd(`CPRC_OFF_PCLKGT, d & `CPRC_GT_MASK, 16'hFFFF);
    end
    done("register traffic");

    for (int i = 0; i < 16; i++)
    begin
      wr(`CPRC_OFF_PSCTL, {4'h8, i[3:0], 8'h01});
      settle();
      chk(clk_b.oe, !i[2], "pin b drive");
      chk(clk_a.oe, !i[0], "pin a drive");
      d[0] = clk_b.o;
      d[1] = clk_a.o;
      @(posedge clk_i);
      #1;
      // Crystal selection stays high; the halved internal clock alternates.
      if (!i[2])
        chk(i[3] ? (clk_b.o & d[0]) : (clk_b.o ^ d[0]), 1'b1, "pin b source");
      if (!i[0])
        chk(i[1] ? (clk_a.o & d[1]) : (clk_a.o ^ d[1]), 1'b1, "pin a source");
    end
    done("clock pins");

    for (int i = 0; i < 8; i++)
    begin
      wr(`CPRC_OFF_PSCTL, 16'h8000 | 16'(i));
      gap(n);
      gap(n);
      chk(n[15:0], 16'(1 << i), "divided period");
    end
    wr(`CPRC_OFF_PSCTL, 16'h0007);
    gap(n);
    gap(n);
    chk(n[15:0], 16'h0001, "full speed period");
    done("divider");

    wr(`CPRC_OFF_PSCTL, 16'h8000);
    rd(`CPRC_OFF_PSCTL, 16'h8000, 16'h8000);
    pulse_irq(2);
    rd(`CPRC_OFF_PSCTL, 16'h0000, 16'h8000);
    done("interrupt clears power save");

    wr(`CPRC_OFF_PSCTL, 16'h8003);
    wr(`CPRC_OFF_PDCFG, 16'h8001);
    settle();
    chk(xtal_stop, 1'b1, "power down");
    pulse_irq(3);
    chk(xtal_stop, 1'b1, "disabled line must not wake");
    pulse_irq(0);
    rd(`CPRC_OFF_PDCFG, 16'h0100, 16'h0100);
    #1;
    chk(xtal_stop, 1'b0, "crystal restarted");
    // The full 2^19 wait would dominate the run; a long slice must stay quiet.
    n = 0;
    repeat (2000)
    begin
      @(posedge clk_i);
      #1;
      if (core_en === 1'b1)
        n++;
    end
    chk(n[15:0], 16'h0000, "clock held during stabilisation");
    done("power down and wake");

    do_reset(1'b0, 1'b0, 1'b1);
    rd(`CPRC_OFF_STRAP, strap_bus, 16'hFFFF);
    #1;
    chk(pin_float, 1'b1, "upper strap floats");
    chk(clk_a.oe, 1'b0, "pin floated");
    gap(n);
    gap(n);
    chk(n[15:0], 16'h0002, "halved input");
    do_reset(1'b1, 1'b1, 1'b0);
    chk(pin_float, 1'b1, "low strap floats");
    gap(n);
    gap(n);
    chk(n[15:0], 16'h0001, "not halved");
    done("straps");

    repeat (3) @(posedge clk_i);
    results();
  end
endmodule // tb_top
